// ==== rtl/rls_setup_regs.sv ====
// radio link setup registers with retransmit control
// Functional notes
// - address width code 01/10/11 selects 3/4/5 bytes; 00 illegal; resets to 11.
// - below five bytes, only the low bytes of stored addresses are used.
// - retry wait is 250 us per step plus 250 us, end to next start.
// - retry limit allows that many retransmissions; zero disables; resets to 0011.
// - seven-bit channel field resets to 0000010; bit 7 reserved, reads zero.
// - radio setup bit 7 enables continuous unmodulated carrier; resets clear.
// - slow/fast rate bits give 1M, 2M, 250k; fast ignored when slow set.
// - radio setup bit 4 forces synthesizer lock, test only, resets zero.
// - registers are reached through the serial register read and write commands.
// - exhausted retries raise a flag; writing 1 clears it before traffic resumes.
// - retry counter restarts from zero when a new packet starts while the exhausted flag is clear.
module rls_setup_regs #(
   parameter int RETRY_STEP_US = rls_pkg::RETRY_STEP_US
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        tx_start,
   input  wire logic        tx_end,
   input  wire logic        ack_ok,
   input  wire logic        retry_flag_clear,
   output logic             resend,
   output logic             retry_exhausted_flag,
   output logic      [3:0]  retry_counter,
   output logic      [2:0]  addr_width_bytes,
   output logic      [4:0]  addr_byte_used,
   output logic      [6:0]  channel_select,
   output logic             carrier_test_tone,
   output logic             force_synth_lock,
   output logic      [1:0]  air_rate,
   output logic      [1:0]  output_power_code
);
   typedef struct packed {
      logic [1:0] addr_width_code;
      logic [7:0] retransmit_setup;
      logic [6:0] channel;
      logic [7:0] radio_setup;
      logic [7:0] rdata;
      logic       flag;
   } rls_bank_s;

   rls_bank_s   st_reg;
   rls_bank_s   st_next;
   logic [7:0]  rd_mux;
   rls_retry_if rif ();

   // parallel side of the serial command decoder
   always_comb begin
      unique case (reg_addr)
         rls_pkg::AW_ADDR:   rd_mux = {6'h00, st_reg.addr_width_code};
         rls_pkg::RETR_ADDR: rd_mux = st_reg.retransmit_setup;
         rls_pkg::CH_ADDR:   rd_mux = {1'b0, st_reg.channel};
         rls_pkg::RFS_ADDR:  rd_mux = st_reg.radio_setup;
         default:            rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      if (reg_rd) begin
         st_next.rdata = rd_mux;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            // reserved bits are dropped on write so they always read zero
            rls_pkg::AW_ADDR:   st_next.addr_width_code = reg_wdata[rls_pkg::AW_LSB +: 2];
            rls_pkg::RETR_ADDR: st_next.retransmit_setup = reg_wdata;
            rls_pkg::CH_ADDR:   st_next.channel = reg_wdata[rls_pkg::CH_LSB +: 7];
            rls_pkg::RFS_ADDR:  st_next.radio_setup = reg_wdata & rls_pkg::RFS_WMASK;
            default: ;
         endcase
      end
      // set beats a clear landing in the same cycle
      if (retry_flag_clear) begin
         st_next.flag = 1'b0;
      end
      if (rif.exhausted) begin
         st_next.flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg.addr_width_code  <= rls_pkg::AW_RST;
         st_reg.retransmit_setup <= rls_pkg::RETR_RST;
         st_reg.channel          <= rls_pkg::CH_RST;
         st_reg.radio_setup      <= rls_pkg::RFS_RST;
         st_reg.rdata            <= 8'h00;
         st_reg.flag             <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rif.delay_code = st_reg.retransmit_setup[rls_pkg::DELAY_LSB +: 4];
   assign rif.limit      = st_reg.retransmit_setup[rls_pkg::LIMIT_LSB +: 4];
   assign rif.hold       = st_reg.flag;
   assign rif.tx_start   = tx_start;
   assign rif.tx_end     = tx_end;
   assign rif.ack_ok     = ack_ok;

   rls_retry_engine #(
      .STEP_US (RETRY_STEP_US)
   ) u_engine (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .rif     (rif)
   );

   // illegal code 00 is left to software; it maps to zero bytes here
   always_comb begin
      unique case (st_reg.addr_width_code)
         2'b01:   addr_width_bytes = 3'h3;
         2'b10:   addr_width_bytes = 3'h4;
         2'b11:   addr_width_bytes = 3'h5;
         default: addr_width_bytes = 3'h0;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_byte_used
         assign addr_byte_used[gi] = (3'(gi) < addr_width_bytes);
      end
   endgenerate

   // reserved combination 11 is not guarded; slow bit wins
   always_comb begin
      if (st_reg.radio_setup[rls_pkg::SLOW_BIT]) begin
         air_rate = rls_pkg::RLS_RATE_250K;
      end else if (st_reg.radio_setup[rls_pkg::FAST_BIT]) begin
         air_rate = rls_pkg::RLS_RATE_2M;
      end else begin
         air_rate = rls_pkg::RLS_RATE_1M;
      end
   end

   assign reg_rdata            = st_reg.rdata;
   assign resend               = rif.resend;
   assign retry_exhausted_flag = st_reg.flag;
   assign retry_counter        = rif.retry_count;
   assign channel_select       = st_reg.channel;
   assign carrier_test_tone    = st_reg.radio_setup[rls_pkg::TONE_BIT];
   assign force_synth_lock     = st_reg.radio_setup[rls_pkg::LOCK_BIT];
   assign output_power_code    = st_reg.radio_setup[rls_pkg::PWR_LSB +: 2];
endmodule

// ==== rtl/rls_pkg.sv ====
// constants and types shared by the radio link setup register bank
package rls_pkg;
   localparam logic [4:0] AW_ADDR    = 5'h03;
   localparam logic [4:0] RETR_ADDR  = 5'h04;
   localparam logic [4:0] CH_ADDR    = 5'h05;
   localparam logic [4:0] RFS_ADDR   = 5'h06;

   localparam logic [1:0] AW_RST     = 2'h3;
   localparam logic [7:0] RETR_RST   = 8'h03;
   localparam logic [6:0] CH_RST     = 7'h02;
   localparam logic [7:0] RFS_RST    = 8'h0F;

   localparam int AW_LSB     = 0;
   localparam int DELAY_LSB  = 4;
   localparam int LIMIT_LSB  = 0;
   localparam int CH_LSB     = 0;
   localparam int TONE_BIT   = 7;
   localparam int SLOW_BIT   = 5;
   localparam int LOCK_BIT   = 4;
   localparam int FAST_BIT   = 3;
   localparam int PWR_LSB    = 1;
   localparam logic [7:0] RFS_WMASK = 8'hBF;

   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int TICK_CYCLES   = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_STEP_US = 250;

   typedef enum logic [1:0] {
      RLS_RATE_1M   = 2'b00,
      RLS_RATE_2M   = 2'b01,
      RLS_RATE_250K = 2'b10
   } rls_rate_e;

   typedef enum logic [1:0] {
      RLS_IDLE   = 2'b00,
      RLS_AWAIT  = 2'b01,
      RLS_TIMING = 2'b10
   } rls_state_e;
endpackage

// ==== rtl/rls_retry_if.sv ====
// signals between the register bank and the retransmit engine
interface rls_retry_if;
   logic [3:0] delay_code;
   logic [3:0] limit;
   logic       hold;
   logic       tx_start;
   logic       tx_end;
   logic       ack_ok;
   logic       resend;
   logic       exhausted;
   logic [3:0] retry_count;

   modport bank (output delay_code, limit, hold, tx_start, tx_end, ack_ok,
                 input  resend, exhausted, retry_count);
   modport engine (input  delay_code, limit, hold, tx_start, tx_end, ack_ok,
                   output resend, exhausted, retry_count);
endinterface

// ==== rtl/rls_retry_engine.sv ====
// retransmit delay timer and retry counter
module rls_retry_engine #(
   parameter int STEP_US = rls_pkg::RETRY_STEP_US
) (
   input  wire logic    sys_clk,
   input  wire logic    sys_rst,
   rls_retry_if.engine  rif
);
   typedef struct packed {
      rls_pkg::rls_state_e state;
      logic [6:0]          tick_cnt;
      logic [11:0]         us_cnt;
      logic [3:0]          count;
      logic                resend;
      logic                exhausted;
   } rls_eng_s;

   rls_eng_s   st_reg;
   rls_eng_s   st_next;
   logic [11:0] target_us;
   logic        tick;

   // wait is (code + 1) steps, 250 us to 4000 us
   assign target_us = 12'(({8'h00, rif.delay_code} + 12'h001) * 12'(STEP_US));
   assign tick      = (st_reg.tick_cnt == 7'(rls_pkg::TICK_CYCLES - 1));

   always_comb begin
      st_next           = st_reg;
      st_next.resend    = 1'b0;
      st_next.exhausted = 1'b0;
      unique case (st_reg.state)
         rls_pkg::RLS_IDLE: ;
         rls_pkg::RLS_AWAIT: begin
            if (rif.tx_end) begin
               st_next.state    = rls_pkg::RLS_TIMING;
               st_next.tick_cnt = 7'h00;
               st_next.us_cnt   = 12'h000;
            end
         end
         rls_pkg::RLS_TIMING: begin
            if (rif.ack_ok) begin
               st_next.state = rls_pkg::RLS_IDLE;
            end else if (tick) begin
               st_next.tick_cnt = 7'h00;
               st_next.us_cnt   = st_reg.us_cnt + 12'h001;
               // no ack inside the wait counts as a failed attempt
               if (st_reg.us_cnt + 12'h001 >= target_us) begin
                  if (st_reg.count == rif.limit) begin
                     st_next.exhausted = 1'b1;
                     st_next.state     = rls_pkg::RLS_IDLE;
                  end else begin
                     st_next.resend = 1'b1;
                     st_next.count  = st_reg.count + 4'h1;
                     st_next.state  = rls_pkg::RLS_AWAIT;
                  end
               end
            end else begin
               st_next.tick_cnt = st_reg.tick_cnt + 7'h01;
            end
         end
         default: st_next.state = rls_pkg::RLS_IDLE;
      endcase
      // a new packet always restarts the count, unless the flag blocks traffic
      if (rif.tx_start && !rif.hold) begin
         st_next.count = 4'h0;
         st_next.state = rls_pkg::RLS_AWAIT;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{state: rls_pkg::RLS_IDLE, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rif.resend      = st_reg.resend;
   assign rif.exhausted   = st_reg.exhausted;
   assign rif.retry_count = st_reg.count;
endmodule

// ==== sim/rls_setup_regs_assertions.sv ====
// checker for the radio link setup register bank
module rls_chk #(
   parameter int RETRY_STEP_US = rls_pkg::RETRY_STEP_US
) (
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic [4:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       tx_start,
   input wire logic       retry_flag_clear,
   input wire logic       resend,
   input wire logic       retry_exhausted_flag,
   input wire logic [3:0] retry_counter,
   input wire logic [2:0] addr_width_bytes,
   input wire logic [4:0] addr_byte_used,
   input wire logic [6:0] channel_select,
   input wire logic       carrier_test_tone,
   input wire logic       force_synth_lock,
   input wire logic [1:0] air_rate,
   input wire logic [1:0] output_power_code
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic aw_wr, ch_wr, rs_wr;
   assign aw_wr = reg_wr && reg_addr == rls_pkg::AW_ADDR;
   assign ch_wr = reg_wr && reg_addr == rls_pkg::CH_ADDR;
   assign rs_wr = reg_wr && reg_addr == rls_pkg::RFS_ADDR;
   a_width_code: assert property (aw_wr && reg_wdata[1:0] != 2'h0 |=>
      addr_width_bytes == $past(reg_wdata[1:0]) + 3'h2) else $error("width code map");
   a_byte_mask: assert property (addr_width_bytes >= 3'h3 |->
      addr_byte_used == 5'h1f >> (3'h5 - addr_width_bytes)) else $error("byte mask");
   a_chan_field: assert property (ch_wr |=>
      channel_select == $past(reg_wdata[6:0])) else $error("channel field");
   a_rate_map: assert property (rs_wr |=> air_rate ==
      {$past(reg_wdata[5]), $past(reg_wdata[3]) & ~$past(reg_wdata[5])}) else $error("rate");
   a_tone_lock: assert property (rs_wr |=> carrier_test_tone == $past(reg_wdata[7])
      && force_synth_lock == $past(reg_wdata[4])) else $error("tone or lock");
   a_power_field: assert property (rs_wr |=>
      output_power_code == $past(reg_wdata[2:1])) else $error("power field");
   a_chan_read: assert property (reg_rd && !reg_wr && reg_addr == rls_pkg::CH_ADDR |=>
      reg_rdata == {1'b0, channel_select}) else $error("channel read");
   a_unmapped_zero: assert property (reg_rd && (reg_addr < 5'h3 || reg_addr > 5'h6) |=>
      reg_rdata == 8'h00) else $error("unmapped read");
   a_count_restart: assert property (tx_start && !retry_exhausted_flag |=>
      retry_counter == 4'h0) else $error("counter restart");
   a_flag_sticky: assert property (retry_exhausted_flag && !retry_flag_clear |=>
      retry_exhausted_flag) else $error("flag dropped");
   cover property (rs_wr);
   cover property (resend);
   cover property ($rose(retry_exhausted_flag));
endmodule

bind rls_setup_regs rls_chk #(.RETRY_STEP_US(RETRY_STEP_US)) i_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start(tx_start),
   .retry_flag_clear(retry_flag_clear), .resend(resend),
   .retry_exhausted_flag(retry_exhausted_flag), .retry_counter(retry_counter),
   .addr_width_bytes(addr_width_bytes), .addr_byte_used(addr_byte_used),
   .channel_select(channel_select), .carrier_test_tone(carrier_test_tone),
   .force_synth_lock(force_synth_lock), .air_rate(air_rate),
   .output_power_code(output_power_code));

// ==== sim/rls_mcu_model.sv ====
// microcontroller side: register commands and flag clear
module rls_mcu_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [4:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   output logic            retry_flag_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {reg_addr, reg_wr, reg_wdata, reg_rd, retry_flag_clear} = '0;
   // released bus shows inverted last value, never a stale copy
   task automatic drop;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
   // callers pass only legal codes with reserved bits zero
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      #1 {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
      @(posedge sys_clk);
      #1 drop();
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      #1 {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge sys_clk);
      #1 v = reg_rdata;
      drop();
   endtask
   task automatic clr;
      @(posedge sys_clk);
      #1 retry_flag_clear = 1'b1;
      @(posedge sys_clk);
      #1 retry_flag_clear = 1'b0;
   endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the radio link setup register bank
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk = 0, sys_rst = 1, tx_start = 0, tx_end = 0, ack_ok = 0;
   logic       clr, wr, rd, resend, flag, tone, lock;
   logic [4:0] addr, used;
   logic [7:0] wdata, rdata, d;
   logic [3:0] cnt;
   logic [2:0] bytes;
   logic [6:0] chan;
   logic [1:0] rate, pwr;
   int         n_fail = 0, check_count = 0, n;
   always #5 sys_clk = ~sys_clk;
   rls_mcu_model i_mcu (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .retry_flag_clear(clr));
   rls_setup_regs #(.RETRY_STEP_US(1)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
      .tx_start(tx_start), .tx_end(tx_end), .ack_ok(ack_ok), .retry_flag_clear(clr),
      .resend(resend), .retry_exhausted_flag(flag), .retry_counter(cnt),
      .addr_width_bytes(bytes), .addr_byte_used(used), .channel_select(chan),
      .carrier_test_tone(tone), .force_synth_lock(lock), .air_rate(rate),
      .output_power_code(pwr));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      @(posedge sys_clk);
      #1 s = 1'b1;
      @(posedge sys_clk);
      #1 s = 1'b0;
   endtask
   task automatic t_reset;
      i_mcu.rd(rls_pkg::AW_ADDR, d); chk("aw", d, 8'h03);
      i_mcu.rd(rls_pkg::RETR_ADDR, d); chk("retr", d, 8'h03);
      i_mcu.rd(rls_pkg::CH_ADDR, d); chk("ch", d, 8'h02);
      i_mcu.rd(rls_pkg::RFS_ADDR, d); chk("rfs", d, 8'h0f);
      chk("rate", rate, 8'h01);
      chk("used", used, 8'h1f);
      chk("chan", chan, 8'h02);
      chk("pwr", pwr, 8'h03);
   endtask
   task automatic t_width;
      for (int c = 1; c < 4; c++) begin
         i_mcu.wr(rls_pkg::AW_ADDR, 8'(c));
         chk("bytes", bytes, 8'(c + 2));
         chk("used", used, 8'((1 << (c + 2)) - 1));
      end
   endtask
   task automatic t_setup;
      logic [7:0] tb[4] = '{8'h80, 8'h1a, 8'h24, 8'h0c};
      foreach (tb[i]) begin
         i_mcu.wr(rls_pkg::RFS_ADDR, tb[i]);
         chk("tone_lock", {tone, lock}, {tb[i][7], tb[i][4]});
         chk("rate", rate, {tb[i][5], tb[i][3] & ~tb[i][5]});
         chk("pwr", pwr, tb[i][2:1]);
         i_mcu.rd(rls_pkg::RFS_ADDR, d); chk("rfs", d, tb[i]);
      end
   endtask
   task automatic t_chan;
      i_mcu.wr(rls_pkg::CH_ADDR, 8'h7f);
      chk("chan", chan, 8'h7f);
      i_mcu.rd(rls_pkg::CH_ADDR, d); chk("ch", d, 8'h7f);
      i_mcu.rd(5'h1f, d); chk("unmapped", d, 8'h00);
      i_mcu.wr(rls_pkg::RETR_ADDR, 8'h5a);
      i_mcu.rd(rls_pkg::RETR_ADDR, d); chk("retr", d, 8'h5a);
   endtask
   // delay code 1, limit 1: one resend then the flag
   task automatic t_retry;
      i_mcu.wr(rls_pkg::RETR_ADDR, 8'h11);
      pulse(tx_start);
      for (int k = 0; k < 2; k++) begin
         pulse(tx_end);
         n = 0;
         while (resend !== 1'b1 && flag !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
         end
         chk("wait", 8'(n >= 199 && n <= 203), 8'h01);
         chk("outcome", {resend, flag}, k ? 8'h01 : 8'h02);
         chk("cnt", cnt, 8'h01);
      end
      pulse(tx_start);
      chk("blocked", cnt, 8'h01);
      i_mcu.clr();
      chk("flag", flag, 8'h00);
      pulse(tx_start);
      chk("restart", cnt, 8'h00);
      pulse(tx_end);
      pulse(ack_ok);
      n = 0;
      repeat (250) begin
         @(posedge sys_clk);
         #1 n += int'(resend === 1'b1);
      end
      chk("acked", 8'(n), 8'h00);
   endtask
   task automatic end_sim;
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      t_reset;
      t_width;
      t_setup;
      t_chan;
      t_retry;
      end_sim;
   end
   // run needs about 720 cycles
   initial begin
      #200_000;
      n_fail++;
      end_sim;
   end
endmodule
